// ===== core/lmft_core.sv
// LED matrix frame timing core with its serial link front end
`timescale 1ns/1ps
module lmft_core
	import lmft_pkg::*;
#(
	parameter int LINES = 64
) (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        sclk,
	input  wire logic        serial_input,
	output logic             serial_output,
	input  wire logic [47:0] led_open_flags,
	input  wire logic [47:0] led_short_flags,
	output logic [47:0]      channel_out,
	output logic [5:0]       scan_line,
	output logic             line_switching,
	output logic             tail_idle,
	output logic             frame_start,
	output logic             grayscale_clock,
	output logic [7:0]       chip_index
);
	localparam int LW = $clog2(LINES);

	// ==========================================================
	// State types
	typedef struct packed {
		logic        busy;
		logic [5:0]  cnt;
		logic [59:0] rx;
		logic [3:0]  cmd;
		logic        carry;
		logic        out;
		logic        req;
		logic [59:0] pkt;
		logic        ack_s1;
		logic        ack_s2;
		logic        ack_seen;
		logic [60:0] tx;
		logic [6:0]  tx_cnt;
		logic        tog;
	} lmft_link_t;

	typedef struct packed {
		logic             req_s1;
		logic             req_s2;
		logic             req_seen;
		logic             ack;
		logic [55:0]      rd;
		logic             sck_s1;
		logic             sck_s2;
		logic             sck_d;
		logic [7:0]       per_cnt;
		logic [7:0]       per;
		logic [8:0]       acc;
		logic             gtick;
		logic [7:0]       chip_id;
		logic [47:0]      cfg0_stage;
		logic [47:0]      cfg1_stage;
		logic [47:0]      cfg0;
		logic [47:0]      cfg1;
		logic [47:0]      cfg2;
		logic [47:0]      cfg3;
		logic [3:0][47:0] opn;
		logic [3:0][47:0] sht;
		logic [47:0]      opn_s1;
		logic [47:0]      opn_s2;
		logic [47:0]      sht_s1;
		logic [47:0]      sht_s2;
		logic             bank;
		logic [LW-1:0]    wr_ptr;
		lmft_phase_t      ph;
		logic [5:0]       line;
		logic [5:0]       sub;
		logic [15:0]      cnt;
		logic [47:0]      ch;
		logic             frame_start;
	} lmft_core_t;

	lmft_link_t  l_r;
	lmft_link_t  l_nxt;
	lmft_core_t  c_r;
	lmft_core_t  c_nxt;
	logic        lrst_s1;
	logic        lrst;
	logic [47:0] mem [0:2*LINES-1];
	logic        mem_we;
	logic [LW:0] mem_wa;
	logic [47:0] mem_rd;

	// ==========================================================
	// Register read selection
	function automatic logic [47:0] reg_word(input logic [3:0] idx, input lmft_core_t s);
		logic [47:0] w;
		w = '0;
		if (idx == REG_CFG0) begin
			w = s.cfg0_stage;
		end else if (idx == REG_CFG1) begin
			w = s.cfg1_stage;
		end else if (idx == REG_CFG2) begin
			w = s.cfg2;
		end else if (idx == REG_CFG3) begin
			w = s.cfg3;
		end else if (idx < REG_SHORT0) begin
			w = s.opn[idx[1:0]];
		end else if (idx <= REG_LAST) begin
			w = s.sht[idx[1:0]];
		end
		return w;
	endfunction

	// ==========================================================
	// Link side, on the serial clock
	always_ff @(posedge sclk) begin
		lrst_s1 <= srst;
		lrst    <= lrst_s1;
	end

	always_comb begin
		l_nxt        = l_r;
		l_nxt.tog    = ~l_r.tog;
		l_nxt.ack_s1 = c_r.ack;
		l_nxt.ack_s2 = l_r.ack_s1;
		l_nxt.out    = serial_input;
		if (!l_r.busy) begin
			if (serial_input) begin
				l_nxt.busy  = 1'b1;
				l_nxt.cnt   = '0;
				l_nxt.cmd   = '0;
				l_nxt.carry = 1'b1;
			end
		end else begin
			l_nxt.rx  = {serial_input, l_r.rx[59:1]};
			l_nxt.cnt = l_r.cnt + 6'd1;
			if (l_r.cnt == 6'(ADDR_LSB - 1)) begin
				l_nxt.cmd = {serial_input, l_r.rx[59:57]};
			end
			if (l_r.cmd == CMD_CHIP_INDEX && l_r.cnt >= 6'(ADDR_LSB)
					&& l_r.cnt < 6'(DATA_LSB)) begin
				l_nxt.out   = serial_input ^ l_r.carry;
				l_nxt.carry = serial_input & l_r.carry;
			end
			if (l_r.cnt == 6'(PKT_BITS - 1)) begin
				l_nxt.busy = 1'b0;
				l_nxt.pkt  = {serial_input, l_r.rx[59:1]};
				l_nxt.req  = ~l_r.req;
			end
		end
		if (l_r.tx_cnt != '0) begin
			l_nxt.out    = l_r.tx[0];
			l_nxt.tx     = {1'b0, l_r.tx[60:1]};
			l_nxt.tx_cnt = l_r.tx_cnt - 7'd1;
		end else if (l_r.ack_s2 != l_r.ack_seen) begin
			l_nxt.ack_seen = l_r.ack_s2;
			l_nxt.tx       = {c_r.rd, CMD_RESPONSE, 1'b1};
			l_nxt.tx_cnt   = 7'(RESP_BITS);
		end
	end

	always_ff @(posedge sclk) begin
		if (lrst) begin
			l_r <= '0;
		end else begin
			l_r <= l_nxt;
		end
	end

	assign serial_output = l_r.out;

	// ==========================================================
	// Frame memory, two banks
	always_ff @(posedge clk) begin
		if (mem_we) begin
			mem[mem_wa] <= l_r.pkt[59:12];
		end
	end

	assign mem_rd = mem[{c_r.bank, c_r.line[LW-1:0]}];

	// ==========================================================
	// Core side, on the system clock
	always_comb begin
		logic [10:0] acc_sum;
		logic [15:0] seg_len;
		logic [15:0] lsw;
		logic [15:0] ext;
		logic [4:0]  mul;
		logic        sub_done;
		logic [3:0]  cmd;
		logic [7:0]  addr;
		acc_sum     = '0;
		c_nxt       = c_r;
		mem_we      = 1'b0;
		mem_wa      = {~c_r.bank, c_r.wr_ptr};
		sub_done    = 1'b0;
		cmd         = l_r.pkt[3:0];
		addr        = l_r.pkt[11:4];
		seg_len     = 16'(c_r.cfg1[SEG_LEN_LSB +: 10]);
		lsw         = (16'(c_r.cfg1[LSW_LSB +: 4]) + 16'd1) * LSW_STEP;
		ext         = 16'(c_r.cfg1[BLK_EXT_LSB +: 6]);
		mul         = 5'(c_r.cfg3[MUL_LSB +: 4]) + 5'd1;
		c_nxt.req_s1 = l_r.req;
		c_nxt.req_s2 = c_r.req_s1;
		c_nxt.sck_s1 = l_r.tog;
		c_nxt.sck_s2 = c_r.sck_s1;
		c_nxt.sck_d  = c_r.sck_s2;
		c_nxt.opn_s1 = led_open_flags;
		c_nxt.opn_s2 = c_r.opn_s1;
		c_nxt.sht_s1 = led_short_flags;
		c_nxt.sht_s2 = c_r.sht_s1;
		c_nxt.frame_start = 1'b0;
		// Serial clock period in system clocks, then rate multiplication
		if (c_r.sck_s2 != c_r.sck_d) begin
			c_nxt.per     = (c_r.per_cnt == 8'hff) ? 8'hff : c_r.per_cnt + 8'd1;
			c_nxt.per_cnt = '0;
		end else if (c_r.per_cnt != 8'hff) begin
			c_nxt.per_cnt = c_r.per_cnt + 8'd1;
		end
		acc_sum     = 11'(c_r.acc) + 11'(mul);
		c_nxt.gtick = 1'b0;
		if (c_r.per == '0) begin
			c_nxt.acc = '0;
		end else if (acc_sum >= 11'(c_r.per)) begin
			c_nxt.gtick = 1'b1;
			c_nxt.acc   = (acc_sum - 11'(c_r.per) >= 11'(c_r.per)) ? '0
				: 9'(acc_sum - 11'(c_r.per));
		end else begin
			c_nxt.acc = 9'(acc_sum);
		end
		// Frame sequencer
		if (c_r.gtick) begin
			case (c_r.ph)
				PH_SEG: begin
					if (c_r.cnt + 16'd1 >= seg_len) begin
						c_nxt.cnt = '0;
						c_nxt.ph  = PH_SWITCH;
					end else begin
						c_nxt.cnt = c_r.cnt + 16'd1;
					end
				end
				PH_SWITCH: begin
					if (c_r.cnt + 16'd1 >= lsw) begin
						c_nxt.cnt = '0;
						if (c_r.line == c_r.cfg0[SCAN_LSB +: 6]) begin
							c_nxt.line = '0;
							if (ext == '0) begin
								sub_done = 1'b1;
							end else begin
								c_nxt.ph = PH_EXTEND;
							end
						end else begin
							c_nxt.line = c_r.line + 6'd1;
							c_nxt.ph   = PH_SEG;
						end
					end else begin
						c_nxt.cnt = c_r.cnt + 16'd1;
					end
				end
				PH_EXTEND: begin
					if (c_r.cnt + 16'd1 >= ext) begin
						c_nxt.cnt = '0;
						sub_done  = 1'b1;
					end else begin
						c_nxt.cnt = c_r.cnt + 16'd1;
					end
				end
				default: begin
				end
			endcase
		end
		if (sub_done) begin
			if (c_r.sub == c_r.cfg0[SUB_LSB +: 6]) begin
				c_nxt.ph = PH_TAIL;
			end else begin
				c_nxt.sub = c_r.sub + 6'd1;
				c_nxt.ph  = PH_SEG;
			end
		end
		// Commands from the link
		if (c_r.req_s2 != c_r.req_seen) begin
			c_nxt.req_seen = c_r.req_s2;
			case (cmd)
				CMD_CHIP_INDEX: begin
					c_nxt.chip_id = addr;
				end
				CMD_WRITE_BCAST: begin
					if (addr[3:0] == REG_CFG0) begin
						c_nxt.cfg0_stage = l_r.pkt[59:12];
					end else if (addr[3:0] == REG_CFG1) begin
						c_nxt.cfg1_stage = l_r.pkt[59:12];
					end else if (addr[3:0] == REG_CFG2) begin
						c_nxt.cfg2 = l_r.pkt[59:12];
					end else if (addr[3:0] == REG_CFG3) begin
						c_nxt.cfg3 = l_r.pkt[59:12];
					end
				end
				CMD_WRITE_ADDR: begin
					if (addr == c_r.chip_id) begin
						mem_we       = 1'b1;
						c_nxt.wr_ptr = (c_r.wr_ptr == LW'(LINES - 1)) ? '0
							: c_r.wr_ptr + LW'(1);
					end
				end
				CMD_VSYNC: begin
					c_nxt.bank        = ~c_r.bank;
					c_nxt.cfg0        = c_r.cfg0_stage;
					c_nxt.cfg1        = c_r.cfg1_stage;
					c_nxt.wr_ptr      = '0;
					c_nxt.ph          = PH_SEG;
					c_nxt.line        = '0;
					c_nxt.sub         = '0;
					c_nxt.cnt         = '0;
					c_nxt.frame_start = 1'b1;
				end
				CMD_READ: begin
					if (addr == c_r.chip_id) begin
						c_nxt.rd  = {reg_word(l_r.pkt[15:12], c_r), c_r.chip_id};
						c_nxt.ack = ~c_r.ack;
						if (l_r.pkt[15:12] >= REG_OPEN0 && l_r.pkt[15:12] < REG_SHORT0) begin
							c_nxt.opn[l_r.pkt[13:12]] = '0;
						end else if (l_r.pkt[15:12] >= REG_SHORT0
								&& l_r.pkt[15:12] <= REG_LAST) begin
							c_nxt.sht[l_r.pkt[13:12]] = '0;
						end
					end
				end
				default: begin
				end
			endcase
		end
		// Fault capture per line group; a new flag beats a read clear
		if (c_r.ph == PH_SEG) begin
			c_nxt.opn[c_r.line[1:0]] = c_nxt.opn[c_r.line[1:0]] | c_r.opn_s2;
			c_nxt.sht[c_r.line[1:0]] = c_nxt.sht[c_r.line[1:0]] | c_r.sht_s2;
		end
		c_nxt.ch = (c_r.ph == PH_SEG) ? mem_rd : '0;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			c_r            <= '0;
			c_r.cfg0_stage <= CFG0_RST;
			c_r.cfg1_stage <= CFG1_RST;
			c_r.cfg0       <= CFG0_RST;
			c_r.cfg1       <= CFG1_RST;
			c_r.cfg2       <= CFG2_RST;
			c_r.cfg3       <= CFG3_RST;
			c_r.ph         <= PH_WAIT;
		end else begin
			c_r <= c_nxt;
		end
	end

	assign channel_out     = c_r.ch;
	assign scan_line       = c_r.line;
	assign line_switching  = (c_r.ph == PH_SWITCH);
	assign tail_idle       = (c_r.ph == PH_TAIL);
	assign frame_start     = c_r.frame_start;
	assign grayscale_clock = c_r.gtick;
	assign chip_index      = c_r.chip_id;
endmodule // lmft_core

// ===== core/lmft_pkg.sv
// Constants and types shared by the LED matrix frame timing core
package lmft_pkg;
	// ==========================================================
	// Serial packet layout, LSB first after a start bit of one
	localparam int PKT_BITS  = 60;
	localparam int ADDR_LSB  = 4;
	localparam int DATA_LSB  = 12;
	localparam int RESP_BITS = 61;
	localparam logic [3:0] CMD_CHIP_INDEX  = 4'h1;
	localparam logic [3:0] CMD_WRITE_BCAST = 4'h2;
	localparam logic [3:0] CMD_WRITE_ADDR  = 4'h3;
	localparam logic [3:0] CMD_VSYNC       = 4'h4;
	localparam logic [3:0] CMD_READ        = 4'h5;
	localparam logic [3:0] CMD_RESPONSE    = 4'h6;
	// ==========================================================
	// Register indices
	localparam logic [3:0] REG_CFG0   = 4'h0;
	localparam logic [3:0] REG_CFG1   = 4'h1;
	localparam logic [3:0] REG_CFG2   = 4'h2;
	localparam logic [3:0] REG_CFG3   = 4'h3;
	localparam logic [3:0] REG_OPEN0  = 4'h4;
	localparam logic [3:0] REG_SHORT0 = 4'h8;
	localparam logic [3:0] REG_LAST   = 4'hb;
	// ==========================================================
	// Field positions
	localparam int SEG_LEN_LSB = 0;
	localparam int LSW_LSB     = 37;
	localparam int BLK_EXT_LSB = 41;
	localparam int SCAN_LSB    = 0;
	localparam int SUB_LSB     = 6;
	localparam int MUL_LSB     = 0;
	localparam logic [15:0] LSW_STEP = 16'h001e;
	// ==========================================================
	// Reset values
	localparam logic [47:0] CFG0_RST = 48'h0000_0000_07dd;
	localparam logic [47:0] CFG1_RST = 48'h0060_0000_0200;
	localparam logic [47:0] CFG2_RST = 48'h0000_0000_0000;
	localparam logic [47:0] CFG3_RST = 48'h0000_0000_0002;
	typedef enum logic [2:0] {PH_WAIT, PH_SEG, PH_SWITCH, PH_EXTEND, PH_TAIL} lmft_phase_t;
endpackage

// ===== bench/lmft_ctrl_model.sv
// Display controller model driving the serial link
`timescale 1ns/1ps
module lmft_ctrl_model (
	input  wire logic sclk,
	output logic      serial_input,
	input  wire logic serial_output
);
	// ==========================================================
	// Packet driver, idle level low between packets
	initial serial_input = 1'b0;
	// Start bit, then command, address, data, LSB first
	task automatic send(input logic [3:0] cmd, input logic [7:0] addr, input logic [47:0] data);
		logic [59:0] pkt;
		pkt = {data, addr, cmd};
		@(negedge sclk) serial_input = 1'b1;
		for (int i = 0; i < 60; i++) begin
			@(negedge sclk) serial_input = pkt[i];
		end
		@(negedge sclk) serial_input = 1'b0;
	endtask
	// Gap between packets, slow or prompt
	task automatic idle(input int n);
		repeat (n) @(negedge sclk);
	endtask
	// Response hunt, bounded, then quiet time
	task automatic get_resp(output logic [59:0] r);
		int n;
		n = 0;
		while (serial_output !== 1'b1 && n < 80) begin
			@(negedge sclk);
			n++;
		end
		for (int i = 0; i < 60; i++) begin
			@(negedge sclk);
			r[i] = serial_output;
		end
		repeat (70) @(negedge sclk);
	endtask
endmodule // lmft_ctrl_model

// ===== bench/lmft_core_chk.sv
// Assertion checker for the frame timing core
`timescale 1ns/1ps
module lmft_core_chk (
	input wire logic        clk,
	input wire logic        srst,
	input wire logic [47:0] channel_out,
	input wire logic [5:0]  scan_line,
	input wire logic        line_switching,
	input wire logic        tail_idle,
	input wire logic        frame_start,
	input wire logic        grayscale_clock
);
	// ==========================================================
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic [9:0] sw_cnt_r;
	always_ff @(posedge clk)
		sw_cnt_r <= (srst || !line_switching) ? 10'h000 : sw_cnt_r + {9'h000, grayscale_clock};
	sequence s_sync_start;
		##[0:2] (scan_line == 6'h00 && !tail_idle);
	endsequence
	property p_fs_single; frame_start |=> !frame_start; endproperty
	property p_fs_scan0; frame_start |-> s_sync_start; endproperty
	property p_tail_dark; tail_idle |-> channel_out == 48'h0000_0000_0000; endproperty
	property p_tail_no_sw; tail_idle |-> !line_switching && scan_line == 6'h00; endproperty
	property p_tail_exit; $fell(tail_idle) |-> (frame_start || $past(frame_start)); endproperty
	property p_sw_dark;
		line_switching && $past(line_switching) |-> channel_out == 48'h0000_0000_0000;
	endproperty
	property p_sw_len;
		$fell(line_switching) && !frame_start && !$past(frame_start) && !$past(frame_start, 2)
			|-> (sw_cnt_r >= 10'h077 && sw_cnt_r <= 10'h079);
	endproperty
	property p_sw_scan;
		line_switching && $past(line_switching) && !frame_start && !$past(frame_start)
			|-> $stable(scan_line);
	endproperty
	property p_grayscale_clock_live; line_switching |-> ##[0:8] grayscale_clock; endproperty
	a_fs_single: assert property (p_fs_single) else $error("sync pulse too long");
	a_fs_scan0: assert property (p_fs_scan0) else $error("frame not restarted");
	a_tail_dark: assert property (p_tail_dark) else $error("channels on in tail");
	a_tail_no_sw: assert property (p_tail_no_sw) else $error("switch in tail");
	a_tail_exit: assert property (p_tail_exit) else $error("tail left without sync");
	a_sw_dark: assert property (p_sw_dark) else $error("channels on in switch");
	a_sw_len: assert property (p_sw_len) else $error("line switch length wrong");
	a_sw_scan: assert property (p_sw_scan) else $error("line moved in switch");
	a_grayscale_clock_live: assert property (p_grayscale_clock_live) else $error("grayscale clock idle");
endmodule // lmft_core_chk
bind lmft_core lmft_core_chk i_chk (.clk(clk), .srst(srst), .channel_out(channel_out),
	.scan_line(scan_line), .line_switching(line_switching), .tail_idle(tail_idle),
	.frame_start(frame_start), .grayscale_clock(grayscale_clock));

// ===== bench/lmft_core_bench.sv
// Self-checking bench for the frame timing core
`timescale 1ns/1ps
module lmft_core_bench;
	import lmft_pkg::*;
	localparam logic [47:0] CFG0_V = 48'h0000_0000_0041;
	localparam logic [47:0] CFG1_V = 48'h0a60_0000_0014;
	localparam logic [7:0]  OWN_ID = 8'h05;
	localparam logic [47:0] CFG3_V = 48'h0000_0000_0001;
	logic        clk = 1'b0;
	logic        sclk = 1'b0;
	logic        srst = 1'b1;
	logic        serial_input;
	logic        serial_output;
	logic [47:0] led_open_flags;
	logic [47:0] led_short_flags;
	logic [47:0] channel_out;
	logic [5:0]  scan_line;
	logic        line_switching;
	logic        tail_idle;
	logic        frame_start;
	logic        grayscale_clock;
	logic [7:0]  chip_index;
	logic [31:0] rng = 32'h0000_4aa1;
	logic [47:0] word_exp [2];
	logic [59:0] resp;
	int          failures = 0;
	int          num_checks = 0;
	int          fs_cnt = 0;
	int          seen [2];
	// ==========================================================
	// Clocks, design and partner
	always #2.5 clk = ~clk;
	initial begin
		#1.3;
		forever #6 sclk = ~sclk;
	end
	lmft_core i_dut (.clk(clk), .srst(srst), .sclk(sclk), .serial_input(serial_input),
		.serial_output(serial_output), .led_open_flags(led_open_flags),
		.led_short_flags(led_short_flags), .channel_out(channel_out), .scan_line(scan_line),
		.line_switching(line_switching), .tail_idle(tail_idle), .frame_start(frame_start),
		.grayscale_clock(grayscale_clock), .chip_index(chip_index));
	lmft_ctrl_model i_ctrl (.sclk(sclk), .serial_input(serial_input),
		.serial_output(serial_output));
	// ==========================================================
	// Helpers
	function logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	function logic [47:0] rnd48();
		logic [63:0] t;
		t = {xs(), xs()};
		return t[47:0] | 48'h0000_0000_0001;
	endfunction
	function logic [59:0] exp_resp(input logic [47:0] v);
		return {v, OWN_ID, CMD_RESPONSE};
	endfunction
	task automatic chk_word(input logic [59:0] got, input logic [59:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_word(60'(got), 60'(exp));
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [3:0] idx, input logic [59:0] exp);
		i_ctrl.send(CMD_READ, a, {44'h000_0000_0000, idx});
		i_ctrl.get_resp(resp);
		chk_word(resp, exp);
	endtask
	task automatic wait_fs(input int k);
		int n;
		n = 0;
		while (fs_cnt < k && n < 2000) begin
			@(negedge clk);
			n++;
		end
		chk_bit(fs_cnt == k, 1'b1);
	endtask
	task automatic wait_tail();
		int n;
		n = 0;
		while (tail_idle !== 1'b1 && n < 4000) begin
			@(negedge clk);
			n++;
		end
		chk_bit(tail_idle, 1'b1);
	endtask
	// Grayscale rate over 600 clocks, which span 250 link periods
	task automatic grayscale_clock_rate(input int factor);
		int n;
		int e;
		n = 0;
		e = 250 * factor;
		repeat (600) begin
			@(negedge clk);
			n += int'(grayscale_clock);
		end
		chk_bit(n * 100 >= e * 88 && n * 100 <= e * 112, 1'b1);
	endtask
	task automatic end_sim();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Display content of the second frame
	always @(negedge clk) begin
		if (frame_start === 1'b1)
			fs_cnt++;
		if (fs_cnt == 2 && channel_out !== 48'h0000_0000_0000) begin
			chk_bit(scan_line < 6'h02, 1'b1);
			chk_word(60'(channel_out), 60'(word_exp[scan_line[0]]));
			seen[scan_line[0]]++;
		end
	end
	// Watchdog, about six times the expected run
	initial begin
		#200000;
		failures++;
		end_sim();
	end
	// ==========================================================
	// Main sequence
	initial begin
		repeat (20) @(negedge clk);
		led_open_flags = rnd48();
		led_short_flags = rnd48();
		srst = 1'b0;
		i_ctrl.idle(4);
		chk_word(60'(chip_index), 60'h000_0000_0000_0000);
		i_ctrl.send(CMD_CHIP_INDEX, OWN_ID, 48'h0000_0000_0000);
		i_ctrl.idle(8);
		chk_word(60'(chip_index), 60'(OWN_ID));
		$display("test chip index done");
		i_ctrl.send(CMD_WRITE_BCAST, {4'h0, REG_CFG0}, CFG0_V);
		i_ctrl.idle(8);
		i_ctrl.send(CMD_WRITE_BCAST, {4'h0, REG_CFG1}, CFG1_V);
		i_ctrl.idle(8);
		i_ctrl.send(CMD_WRITE_BCAST, {4'h0, REG_CFG2}, CFG2_RST);
		i_ctrl.idle(8);
		i_ctrl.send(CMD_WRITE_BCAST, {4'h0, REG_CFG3}, CFG3_V);
		i_ctrl.idle(8);
		rd_chk(OWN_ID, REG_CFG1, exp_resp(CFG1_V));
		rd_chk(8'h09, REG_CFG1, 60'h000_0000_0000_0000);
		rd_chk(OWN_ID, REG_CFG3, exp_resp(CFG3_V));
		grayscale_clock_rate(int'(CFG3_V[MUL_LSB +: 4]) + 1);
		$display("test config done");
		i_ctrl.send(CMD_VSYNC, 8'h00, 48'h0000_0000_0000);
		wait_fs(1);
		i_ctrl.idle(8);
		word_exp[0] = rnd48();
		word_exp[1] = rnd48();
		i_ctrl.send(CMD_WRITE_ADDR, OWN_ID, word_exp[0]);
		i_ctrl.idle(8);
		i_ctrl.send(CMD_WRITE_ADDR, 8'h09, rnd48());
		i_ctrl.idle(8);
		i_ctrl.send(CMD_WRITE_ADDR, OWN_ID, word_exp[1]);
		i_ctrl.idle(8);
		wait_tail();
		i_ctrl.send(CMD_VSYNC, 8'h00, 48'h0000_0000_0000);
		wait_fs(2);
		i_ctrl.idle(8);
		rd_chk(OWN_ID, REG_CFG0, exp_resp(CFG0_V));
		wait_tail();
		chk_bit(seen[0] > 0 && seen[1] > 0, 1'b1);
		$display("test frame done");
		rd_chk(OWN_ID, REG_OPEN0, exp_resp(led_open_flags));
		rd_chk(OWN_ID, REG_OPEN0, exp_resp(48'h0000_0000_0000));
		rd_chk(OWN_ID, 4'h9, exp_resp(led_short_flags));
		$display("test flags done");
		end_sim();
	end
endmodule // lmft_core_bench
